//--- dv/gofr_framer_props.sv
// checker: trigger and stream relations at the framer ports
`timescale 1ns/10ps
`default_nettype none
module gofr_framer_props
  import gofr_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_sol_valid,
  input wire gofr_sol_s   i_sol,
  input wire logic        i_imu_tick,
  input wire logic        i_tx_ready,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_data,
  input wire logic        o_tx_first,
  input wire logic        o_tx_last
);
  logic [15:0] mask_r;
  logic [15:0] div_r;
  logic        match_r;
  logic [1:0]  quiet_r;
  logic [6:0]  nb_r;
  logic        idle;
  logic        go;

  // ====
  // helpers
  // mirror of control writes so triggers can be judged
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      mask_r  <= GOFR_MASK_RST;
      match_r <= GOFR_MATCH_RST;
      div_r   <= GOFR_DIV_RST;
    end else if (i_wr && i_addr == GOFR_REG_CTRL) begin
      mask_r  <= i_wdata[15:0];
      match_r <= i_wdata[GOFR_CTRL_MATCH];
    end else if (i_wr && i_addr == GOFR_REG_DIV) begin
      div_r <= i_wdata[15:0];
    end
  end
  // three quiet cycles mean no packet can be pending
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b || o_tx_valid || i_sol_valid || i_imu_tick) begin
      quiet_r <= 2'h0;
    end else if (quiet_r != 2'h3) begin
      quiet_r <= quiet_r + 2'h1;
    end
  end
  // bytes already taken in the current packet
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      nb_r <= 7'h00;
    end else if (o_tx_valid && i_tx_ready) begin
      nb_r <= o_tx_last ? 7'h00 : nb_r + 7'h01;
    end
  end
  assign idle = quiet_r == 2'h3;
  assign go   = mask_r[12:0] != 13'h0;

  // expected packet length; mask is assumed steady within a packet
  function automatic logic [6:0] plen(input logic [15:0] m);
    logic [4:0] ln [13];
    plen = 7'h00;
    ln = '{GOFR_LEN_CAL, GOFR_LEN_TOW, GOFR_LEN_WEEK, GOFR_LEN_BYTE,
      GOFR_LEN_BYTE, GOFR_LEN_TRID, GOFR_LEN_TRID, GOFR_LEN_TRIF,
      GOFR_LEN_TRIF, GOFR_LEN_TRIF, GOFR_LEN_FLT, GOFR_LEN_FLT,
      GOFR_LEN_TSTAT};
    for (int i = 0; i < 13; i++) begin
      if (m[i]) plen = plen + 7'(ln[i]);
    end
  endfunction

  // ====
  // properties
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_match;
    match_r && i_sol_valid && idle && go |-> ##2 o_tx_valid && o_tx_first;
  endproperty
  a_match: assert property (p_match)
    else $error("no packet after solution");
  property p_sol_ign;
    !match_r && i_sol_valid && !i_imu_tick && idle |-> ##2 !o_tx_valid;
  endproperty
  a_sol_ign: assert property (p_sol_ign)
    else $error("solution started packet in divisor mode");
  property p_div1;
    !match_r && div_r <= 16'h1 && i_imu_tick && idle && go
      |-> ##2 o_tx_valid && o_tx_first;
  endproperty
  a_div1: assert property (p_div1)
    else $error("no packet after sample tick");
  property p_zero;
    mask_r == 16'h0 && idle |-> ##2 !o_tx_valid;
  endproperty
  a_zero: assert property (p_zero)
    else $error("packet with empty mask");
  property p_hi;
    mask_r[15:13] != 3'h0 && !go && (i_sol_valid || i_imu_tick) && idle
      |-> ##1 !o_tx_valid ##1 !o_tx_valid;
  endproperty
  a_hi: assert property (p_hi)
    else $error("packet from unlaid fields only");
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)
      && $stable(o_tx_first) && $stable(o_tx_last);
  endproperty
  a_hold: assert property (p_hold)
    else $error("byte changed while stalled");
  property p_first;
    o_tx_valid && o_tx_first |-> nb_r == 7'h00;
  endproperty
  a_first: assert property (p_first)
    else $error("first marker inside packet");
  property p_len;
    o_tx_valid && o_tx_last |-> nb_r + 7'h01 == plen(mask_r);
  endproperty
  a_len: assert property (p_len)
    else $error("packet length wrong");
endmodule
`default_nettype wire

//--- dv/gofr_framer_tb.sv
// self-checking bench for the gnss output group framer
`timescale 1ns/10ps
`default_nettype none
module gofr_framer_tb
  import gofr_pkg::*;
;
  logic        i_ref_clk   = 1'b0;
  logic        i_rst_b     = 1'b0;
  logic [7:0]  i_addr      = 8'h00;
  logic [31:0] i_wdata     = 32'h0;
  logic        i_wr        = 1'b0;
  logic        i_rd        = 1'b0;
  logic        i_sol_valid = 1'b0;
  logic        i_imu_tick  = 1'b0;
  logic        slow        = 1'b0;
  gofr_sol_s   i_sol       = '0;
  logic        i_tx_ready;
  logic [31:0] o_rdata;
  logic        o_tx_valid;
  logic [7:0]  o_tx_data;
  logic        o_tx_first;
  logic        o_tx_last;
  int          miscompares = 0;
  int          n_tests     = 0;
  logic [7:0]  exp_q[$];

  always #5 i_ref_clk = ~i_ref_clk;

  gofr_framer #(.DIV_W(16)) dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sol_valid(i_sol_valid), .i_sol(i_sol), .i_imu_tick(i_imu_tick),
    .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_first(o_tx_first), .o_tx_last(o_tx_last)
  );
  gofr_host host_u (
    .i_clk(i_ref_clk), .i_slow(slow), .i_valid(o_tx_valid),
    .i_data(o_tx_data), .i_first(o_tx_first), .i_last(o_tx_last),
    .o_ready(i_tx_ready)
  );

  // ====
  // common tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  // a new solution pattern, distinct per k modulo 11
  task automatic mk(input int k);
    for (int i = 0; i < $bits(gofr_sol_s); i++) begin
      i_sol[i] <= ((i * 37 + k) % 11) > 4;
    end
  endtask
  task automatic pulse(input logic tick);
    @(posedge i_ref_clk);
    if (tick) i_imu_tick <= 1'b1;
    else i_sol_valid <= 1'b1;
    @(posedge i_ref_clk);
    i_imu_tick  <= 1'b0;
    i_sol_valid <= 1'b0;
  endtask
  task automatic clr;
    host_u.rx_q.delete();
    host_u.n_pkt = 0;
  endtask
  task automatic wait_pkts(input int n);
    for (int i = 0; i < 3000 && host_u.n_pkt < n; i++) @(posedge i_ref_clk);
    repeat (10) @(posedge i_ref_clk);
  endtask
  task automatic put(input logic [63:0] v, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(v[8*i +: 8]);
  endtask
  task automatic put3(input logic [63:0] a, b, c, input int n);
    put(a, n);
    put(b, n);
    put(c, n);
  endtask
  // expected payload, fields ascending and low byte first
  task automatic build(input gofr_sol_s s, input logic [15:0] m);
    exp_q = {};
    if (m[0]) put({s.second, s.minute, s.hour, s.day, s.month, s.year}, 6);
    if (m[0]) put(s.msec, 2);
    if (m[1]) put(s.tow_ns, 8);
    if (m[2]) put(s.week, 2);
    if (m[3]) put(s.tracked_count_field, 1);
    if (m[4]) put(s.fix_kind, 1);
    if (m[5]) put3(s.lat, s.lon, s.hgt, 8);
    if (m[6]) put3(s.ecef_x, s.ecef_y, s.ecef_z, 8);
    if (m[7]) put3(s.vel_n, s.vel_e, s.vel_d, 4);
    if (m[8]) put3(s.vel_x, s.vel_y, s.vel_z, 4);
    if (m[9]) put3(s.sig_n, s.sig_e, s.sig_d, 4);
    if (m[10]) put(s.velocity_sigma_field, 4);
    if (m[11]) put(s.time_sigma_field, 4);
    if (m[12]) put({s.leap_count, 5'h0, s.calendar_time_valid_flag,
      s.week_number_valid_flag, s.week_time_valid_flag}, 2);
  endtask
  task automatic cmp(input int n);
    chk(host_u.n_pkt, n);
    chk(host_u.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) chk(host_u.rx_q[i], exp_q[i]);
  endtask

  // ====
  // scenarios
  task automatic t_regs;
    rd(GOFR_REG_CTRL, 32'h0);
    rd(GOFR_REG_DIV, 32'h1);
    rd(8'h14, 32'h0);
    wr(GOFR_REG_CTRL, 32'h0001_1FFF);
    rd(GOFR_REG_CTRL, 32'h0001_1FFF);
  endtask
  // every laid-out field at once, host stalling
  task automatic t_full;
    slow <= 1'b1;
    mk(1);
    pulse(1'b0);
    wait_pkts(1);
    build(i_sol, 16'h1FFF);
    cmp(1);
    slow <= 1'b0;
  endtask
  // all fix codes and flags; a second solution mid-packet is dropped
  task automatic t_kinds;
    gofr_sol_s s0;
    wr(GOFR_REG_CTRL, 32'h0001_1010);
    for (int k = 0; k < 4; k++) begin
      clr;
      mk(k + 5);
      i_sol.fix_kind                 <= 8'(k);
      i_sol.week_time_valid_flag     <= k[0];
      i_sol.week_number_valid_flag   <= k[1];
      i_sol.calendar_time_valid_flag <= k == 3;
      i_sol.leap_count               <= 8'hFE - 8'(k);
      pulse(1'b0);
      s0 = i_sol;
      mk(k + 9);
      pulse(1'b0);
      wait_pkts(2);
      build(s0, 16'h1010);
      cmp(1);
    end
  endtask
  // divisor timing; packet holds last delivered solution
  task automatic t_div;
    gofr_sol_s s0;
    wr(GOFR_REG_CTRL, 32'h0000_0018);
    wr(GOFR_REG_DIV, 32'h1);
    clr;
    mk(3);
    pulse(1'b0);
    s0 = i_sol;
    mk(4);
    wait_pkts(1);
    chk(host_u.n_pkt, 0);
    pulse(1'b1);
    wait_pkts(1);
    build(s0, 16'h0018);
    cmp(1);
    wr(GOFR_REG_DIV, 32'h3);
    clr;
    repeat (6) begin
      pulse(1'b1);
      repeat (20) @(posedge i_ref_clk);
    end
    chk(host_u.n_pkt, 2);
  endtask
  // empty mask and mask of unlaid fields send nothing
  task automatic t_zero;
    wr(GOFR_REG_CTRL, 32'h0001_0000);
    clr;
    pulse(1'b0);
    wait_pkts(1);
    chk(host_u.n_pkt, 0);
    wr(GOFR_REG_CTRL, 32'h0001_E000);
    pulse(1'b0);
    wait_pkts(1);
    chk(host_u.n_pkt, 0);
    // totals: 4 dropped triggers, 8 packets, 12 solutions
    rd(GOFR_REG_STAT, 32'h0004_0000);
    rd(GOFR_REG_PKTCNT, 32'h8);
    rd(GOFR_REG_SOLCNT, 32'hC);
  endtask

  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_regs;
    t_full;
    t_kinds;
    t_div;
    t_zero;
    chk(host_u.n_err, 0);
    print_verdict;
  end
  // watchdog well past the expected run length
  initial begin
    repeat (50000) @(posedge i_ref_clk);
    miscompares++;
    print_verdict;
  end
endmodule

bind gofr_framer gofr_framer_props #(.DIV_W(DIV_W)) props_u (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_sol_valid(i_sol_valid), .i_sol(i_sol), .i_imu_tick(i_imu_tick),
  .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
  .o_tx_data(o_tx_data), .o_tx_first(o_tx_first), .o_tx_last(o_tx_last)
);
`default_nettype wire

//--- dv/gofr_host.sv
// host model: takes framer bytes with prompt or slow ready
`timescale 1ns/10ps
`default_nettype none
module gofr_host (
  input  wire logic       i_clk,
  input  wire logic       i_slow,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_first,
  input  wire logic       i_last,
  output logic            o_ready
);
  logic [1:0] ph_r   = 2'h0;
  logic       in_pkt = 1'b0;
  logic [7:0] rx_q[$];
  int         n_pkt  = 0;
  int         n_err  = 0;

  // slow mode takes one byte in four to exercise the stall path
  assign o_ready = !i_slow || ph_r == 2'h0;
  always @(posedge i_clk) begin
    ph_r <= ph_r + 2'h1;
  end
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      rx_q.push_back(i_data);
      if (i_first == in_pkt) n_err++;
      in_pkt = !i_last;
      if (i_last) n_pkt++;
    end
  end
endmodule
`default_nettype wire

//--- src/gofr_framer.sv
// gnss output group framer: snapshot, rate timing and byte serialiser
`timescale 1ns/10ps
`default_nettype none
module gofr_framer
  import gofr_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_sol_valid,
  input  wire gofr_sol_s   i_sol,
  input  wire logic        i_imu_tick,
  input  wire logic        i_tx_ready,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_data,
  output logic             o_tx_first,
  output logic             o_tx_last
);

  // ==========================================================
  // field helpers

  // byte image of one field, byte 0 in bits 7:0
  function automatic logic [191:0] field_vec(input gofr_sol_s s,
                                             input logic [3:0] f);
    field_vec = '0;
    case (f)
      // [R7] calendar layout
      GOFR_F_CAL:   field_vec = 192'({s.msec, s.second, s.minute,
                                      s.hour, s.day, s.month, s.year});
      // [R8] nanosecond count
      GOFR_F_TOW:   field_vec = 192'(s.tow_ns);
      // [R9] week number
      GOFR_F_WEEK:  field_vec = 192'(s.week);
      // [R10] tracked count byte
      GOFR_F_CNT:   field_vec = 192'(s.tracked_count_field);
      // [R11] solution kind byte
      GOFR_F_KIND:  field_vec = 192'(s.fix_kind);
      // [R12] lat lon height
      GOFR_F_GEO:   field_vec = {s.hgt, s.lon, s.lat};
      // [R13] earth-fixed metres
      GOFR_F_ECEFP: field_vec = {s.ecef_z, s.ecef_y, s.ecef_x};
      // [R14] north east down
      GOFR_F_VLL:   field_vec = 192'({s.vel_d, s.vel_e, s.vel_n});
      // [R15] x y z velocity
      GOFR_F_VECEF: field_vec = 192'({s.vel_z, s.vel_y, s.vel_x});
      // [R16] position sigmas
      GOFR_F_PSIG:  field_vec = 192'({s.sig_d, s.sig_e, s.sig_n});
      // [R17] velocity sigma
      GOFR_F_VSIG:  field_vec = 192'(s.velocity_sigma_field);
      // [R18] time sigma
      GOFR_F_TSIG:  field_vec = 192'(s.time_sigma_field);
      // [R19] [R20] [R22] flags then leap, reserved zero
      GOFR_F_TSTAT: field_vec = 192'({s.leap_count, 5'h00,
                                      s.calendar_time_valid_flag,
                                      s.week_number_valid_flag,
                                      s.week_time_valid_flag});
      default:      field_vec = '0;
    endcase
  endfunction

  // byte count of one field
  function automatic logic [4:0] field_len(input logic [3:0] f);
    case (f)
      GOFR_F_CAL:   field_len = GOFR_LEN_CAL;
      GOFR_F_TOW:   field_len = GOFR_LEN_TOW;
      GOFR_F_WEEK:  field_len = GOFR_LEN_WEEK;
      GOFR_F_CNT:   field_len = GOFR_LEN_BYTE;
      GOFR_F_KIND:  field_len = GOFR_LEN_BYTE;
      GOFR_F_GEO:   field_len = GOFR_LEN_TRID;
      GOFR_F_ECEFP: field_len = GOFR_LEN_TRID;
      GOFR_F_VLL:   field_len = GOFR_LEN_TRIF;
      GOFR_F_VECEF: field_len = GOFR_LEN_TRIF;
      GOFR_F_PSIG:  field_len = GOFR_LEN_TRIF;
      GOFR_F_VSIG:  field_len = GOFR_LEN_FLT;
      GOFR_F_TSIG:  field_len = GOFR_LEN_FLT;
      GOFR_F_TSTAT: field_len = GOFR_LEN_TSTAT;
      default:      field_len = GOFR_LEN_BYTE;
    endcase
  endfunction

  // lowest enabled field at or above from; bit 4 of result = found
  function automatic logic [4:0] next_field(input logic [15:0] en,
                                            input logic [4:0]  from);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (en[i] && (5'(i) >= from)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // registers and state
  logic [15:0]      mask_r;
  logic             match_r;
  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] tick_cnt_r;
  logic [15:0]      ovr_cnt_r;
  logic [31:0]      pkt_cnt_r;
  logic [31:0]      sol_cnt_r;
  gofr_sol_s        sol_r;
  gofr_sol_s        pkt_r;
  gofr_state_e      state_r;
  logic [3:0]       fld_r;
  logic [4:0]       idx_r;
  logic             first_r;
  logic [31:0]      rdata_r;
  logic             tx_valid_r;
  logic [7:0]       tx_data_r;
  logic             tx_first_r;
  logic             tx_last_r;

  logic [15:0]      en_mask;
  logic [4:0]       first_fld;
  logic [4:0]       after_fld;
  logic             trig;
  logic             start;
  logic             div_hit;
  logic             load;
  logic             fld_end;
  gofr_sol_s        sol_now;
  logic [191:0]     cur_vec;

  // [R4] [R5] [R6] only fields with a byte layout are sendable
  assign en_mask   = mask_r & GOFR_IMPL_MASK;
  // [R21] ascending order, first enabled field starts the packet
  assign first_fld = next_field(en_mask, 5'h00);
  assign after_fld = next_field(en_mask, {1'b0, fld_r} + 5'h01);
  // newest solution, including one arriving this very cycle
  assign sol_now   = i_sol_valid ? i_sol : sol_r;
  // divisor zero behaves as one so the timer never stalls
  assign div_hit   = i_imu_tick &&
                     ((div_r == '0) || (tick_cnt_r >= div_r - 1'b1));
  // [R2] match mode sends per receiver update
  // [R3] otherwise the imu tick divisor paces packets
  assign trig      = match_r ? i_sol_valid : div_hit;
  assign start     = trig && (state_r == GOFR_IDLE) && first_fld[4];
  assign load      = (state_r == GOFR_SEND) &&
                     (!tx_valid_r || i_tx_ready);
  assign fld_end   = (idx_r == field_len(fld_r) - 5'h01);
  assign cur_vec   = field_vec(pkt_r, fld_r);

  // ==========================================================
  // register writes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      mask_r  <= GOFR_MASK_RST;
      match_r <= GOFR_MATCH_RST;
      div_r   <= DIV_W'(GOFR_DIV_RST);
    end else if (i_wr) begin
      if (i_addr == GOFR_REG_CTRL) begin
        mask_r  <= i_wdata[15:0];
        match_r <= i_wdata[GOFR_CTRL_MATCH];
      end
      if (i_addr == GOFR_REG_DIV) begin
        div_r <= i_wdata[DIV_W-1:0];
      end
    end
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rdata_r <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        GOFR_REG_CTRL:   rdata_r <= {15'h0000, match_r, mask_r};
        GOFR_REG_DIV:    rdata_r <= 32'(div_r);
        GOFR_REG_STAT:   rdata_r <= {ovr_cnt_r, 14'h0000, tx_valid_r,
                                     (state_r == GOFR_SEND)};
        GOFR_REG_PKTCNT: rdata_r <= pkt_cnt_r;
        GOFR_REG_SOLCNT: rdata_r <= sol_cnt_r;
        default:         rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // [R1] solution store refreshes only on a new solution
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      sol_r     <= '0;
      sol_cnt_r <= 32'h0000_0000;
    end else if (i_sol_valid) begin
      sol_r     <= i_sol;
      sol_cnt_r <= sol_cnt_r + 32'h0000_0001;
    end
  end

  // [R3] imu tick divider, free running in either mode
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tick_cnt_r <= '0;
    end else if (div_hit) begin
      tick_cnt_r <= '0;
    end else if (i_imu_tick) begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  // a trigger while the walk is in GOFR_SEND, up to and including the cycle its last byte is loaded, is dropped and counted;
  // queueing it would only send stale data late
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      ovr_cnt_r <= 16'h0000;
      pkt_cnt_r <= 32'h0000_0000;
    end else begin
      if (trig && (state_r == GOFR_SEND)) begin
        ovr_cnt_r <= ovr_cnt_r + 16'h0001;
      end
      if (start) begin
        pkt_cnt_r <= pkt_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ==========================================================
  // packet walk; the frame snapshot keeps every field of one
  // packet from the same solution
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state_r <= GOFR_IDLE;
      fld_r   <= 4'h0;
      idx_r   <= 5'h00;
      first_r <= 1'b0;
      pkt_r   <= '0;
    end else begin
      case (state_r)
        GOFR_IDLE: begin
          if (start) begin
            state_r <= GOFR_SEND;
            fld_r   <= first_fld[3:0];
            idx_r   <= 5'h00;
            first_r <= 1'b1;
            pkt_r   <= sol_now;
          end
        end
        GOFR_SEND: begin
          if (load) begin
            first_r <= 1'b0;
            // [R21] next enabled field follows with no padding
            if (fld_end) begin
              idx_r <= 5'h00;
              if (after_fld[4]) begin
                fld_r <= after_fld[3:0];
              end else begin
                state_r <= GOFR_IDLE;
              end
            end else begin
              idx_r <= idx_r + 5'h01;
            end
          end
        end
        default: begin
          state_r <= GOFR_IDLE;
        end
      endcase
    end
  end

  // output byte register; holds until the host takes it
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_first_r <= 1'b0;
      tx_last_r  <= 1'b0;
    end else if (load) begin
      tx_valid_r <= 1'b1;
      // [R22] least significant byte first
      tx_data_r  <= cur_vec[{idx_r, 3'b000} +: 8];
      tx_first_r <= first_r;
      tx_last_r  <= fld_end && !after_fld[4];
    end else if (i_tx_ready) begin
      tx_valid_r <= 1'b0;
    end
  end

  assign o_rdata    = rdata_r;
  assign o_tx_valid = tx_valid_r;
  assign o_tx_data  = tx_data_r;
  assign o_tx_first = tx_first_r;
  assign o_tx_last  = tx_last_r;

endmodule
`default_nettype wire

//--- src/gofr_pkg.sv
// constants, types and field layouts of the gnss output group framer
//
// Behaviour
// [R1] group values refresh only on new receiver solution
// [R2] rate equal to receiver rate: send per update
// [R3] other rates: divisor over imu sample ticks
// [R4] mask bits 0-4: time, week time, week, count, kind
// [R5] mask bits 5-11: positions, velocities, uncertainties
// [R6] mask bits 12-15: time status, dilution, satellites, raw; only bit 12 is sent, bits 13-15 are masked off
// [R7] calendar time: year, month..second, 16-bit milliseconds
// [R8] week time: unsigned 64-bit nanoseconds
// [R9] week number: unsigned 16 bits
// [R10] tracked satellite count: one unsigned byte
// [R11] solution kind byte: none, time, 2d, 3d
// [R12] geodetic position: three doubles, 24 bytes
// [R13] earth-fixed position in metres
// [R14] local-level velocity: three floats north east down
// [R15] earth-fixed velocity: three floats x y z
// [R16] position uncertainty: three floats north east down
// [R17] velocity uncertainty: one float
// [R18] time uncertainty: one float, four bytes
// [R19] time status: flag byte then signed leap count
// [R20] flag bits 0-2 valid, bits 3-7 reserved
// [R21] enabled fields ascending by bit, no padding
// [R22] little-endian bytes, reserved bits zero
package gofr_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0]  GOFR_REG_CTRL    = 8'h00;
  localparam logic [7:0]  GOFR_REG_DIV     = 8'h04;
  localparam logic [7:0]  GOFR_REG_STAT    = 8'h08;
  localparam logic [7:0]  GOFR_REG_PKTCNT  = 8'h0C;
  localparam logic [7:0]  GOFR_REG_SOLCNT  = 8'h10;
  localparam int          GOFR_CTRL_MATCH  = 16;
  localparam logic [15:0] GOFR_MASK_RST    = 16'h0000;
  localparam logic        GOFR_MATCH_RST   = 1'b0;
  localparam logic [15:0] GOFR_DIV_RST     = 16'h0001;
  // fields 13..15 have no byte layout here and are never sent
  localparam logic [15:0] GOFR_IMPL_MASK   = 16'h1FFF;

  // ==========================================================
  // selection bit of each field
  localparam logic [3:0] GOFR_F_CAL   = 4'h0;
  localparam logic [3:0] GOFR_F_TOW   = 4'h1;
  localparam logic [3:0] GOFR_F_WEEK  = 4'h2;
  localparam logic [3:0] GOFR_F_CNT   = 4'h3;
  localparam logic [3:0] GOFR_F_KIND  = 4'h4;
  localparam logic [3:0] GOFR_F_GEO   = 4'h5;
  localparam logic [3:0] GOFR_F_ECEFP = 4'h6;
  localparam logic [3:0] GOFR_F_VLL   = 4'h7;
  localparam logic [3:0] GOFR_F_VECEF = 4'h8;
  localparam logic [3:0] GOFR_F_PSIG  = 4'h9;
  localparam logic [3:0] GOFR_F_VSIG  = 4'hA;
  localparam logic [3:0] GOFR_F_TSIG  = 4'hB;
  localparam logic [3:0] GOFR_F_TSTAT = 4'hC;
  localparam logic [3:0] GOFR_F_DOP   = 4'hD;
  localparam logic [3:0] GOFR_F_SAT   = 4'hE;
  localparam logic [3:0] GOFR_F_RAW   = 4'hF;

  // ==========================================================
  // field lengths in bytes
  localparam logic [4:0] GOFR_LEN_CAL   = 5'h08;
  localparam logic [4:0] GOFR_LEN_TOW   = 5'h08;
  localparam logic [4:0] GOFR_LEN_WEEK  = 5'h02;
  localparam logic [4:0] GOFR_LEN_BYTE  = 5'h01;
  localparam logic [4:0] GOFR_LEN_TRID  = 5'h18;
  localparam logic [4:0] GOFR_LEN_TRIF  = 5'h0C;
  localparam logic [4:0] GOFR_LEN_FLT   = 5'h04;
  localparam logic [4:0] GOFR_LEN_TSTAT = 5'h02;

  // solution kind codes and flag bits
  localparam logic [7:0] GOFR_KIND_NONE = 8'h00;
  localparam logic [7:0] GOFR_KIND_TIME = 8'h01;
  localparam logic [7:0] GOFR_KIND_2D   = 8'h02;
  localparam logic [7:0] GOFR_KIND_3D   = 8'h03;
  localparam int         GOFR_FLG_WTIME = 0;
  localparam int         GOFR_FLG_WNUM  = 1;
  localparam int         GOFR_FLG_CAL   = 2;

  // one receiver solution; floats and doubles are raw ieee bits,
  // year is already the signed offset from 2000
  typedef struct packed {
    logic [7:0]  year;
    logic [7:0]  month;
    logic [7:0]  day;
    logic [7:0]  hour;
    logic [7:0]  minute;
    logic [7:0]  second;
    logic [15:0] msec;
    logic [63:0] tow_ns;
    logic [15:0] week;
    logic [7:0]  tracked_count_field;
    logic [7:0]  fix_kind;
    logic [63:0] lat;
    logic [63:0] lon;
    logic [63:0] hgt;
    logic [63:0] ecef_x;
    logic [63:0] ecef_y;
    logic [63:0] ecef_z;
    logic [31:0] vel_n;
    logic [31:0] vel_e;
    logic [31:0] vel_d;
    logic [31:0] vel_x;
    logic [31:0] vel_y;
    logic [31:0] vel_z;
    logic [31:0] sig_n;
    logic [31:0] sig_e;
    logic [31:0] sig_d;
    logic [31:0] velocity_sigma_field;
    logic [31:0] time_sigma_field;
    logic        calendar_time_valid_flag;
    logic        week_number_valid_flag;
    logic        week_time_valid_flag;
    logic [7:0]  leap_count;
  } gofr_sol_s;

  typedef enum logic [0:0] {
    GOFR_IDLE = 1'b0,
    GOFR_SEND = 1'b1
  } gofr_state_e;

endpackage
